/* File: verification/slsu_mem_model.sv */
// Memory system partner model that answers the unit's bus requests
`timescale 1ns/10ps
`default_nettype none
module slsu_mem_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Request from the unit
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic        mem_byte,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	input  wire logic        user_translate_n,
	// Answer to the unit
	output logic             mem_ack,
	output logic             mem_abort,
	output logic [31:0]      mem_rdata,
	// Test control
	input  wire logic        abort_en,
	input  wire logic [1:0]  wait_n,
	output logic             user_translate_n_q
);
	logic [31:0] mem [0:63];
	logic [1:0]  cnt_q;

	// ------------------------------------------------
	// Answer after wait_n cycles, one cycle long
	// ------------------------------------------------
	// Data lines toggle when idle and after an answer, and hold during wait cycles, so stale data never looks valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 2'h0;
			mem_ack <= 1'b0;
			mem_abort <= 1'b0;
			mem_rdata <= 32'h0000_0000;
			user_translate_n_q <= 1'b1;
		end else if (mem_ack || mem_abort) begin
			mem_ack <= 1'b0;
			mem_abort <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt_q <= 2'h0;
			if (mem_ack && mem_we && mem_byte) begin
				mem[mem_addr[7:2]][8*mem_addr[1:0] +: 8] <= mem_wdata[8*mem_addr[1:0] +: 8];
			end else if (mem_ack && mem_we) begin
				mem[mem_addr[7:2]] <= mem_wdata;
			end
		end else if (mem_req && cnt_q == wait_n) begin
			mem_ack <= !abort_en;
			mem_abort <= abort_en;
			mem_rdata <= mem[mem_addr[7:2]];
			user_translate_n_q <= user_translate_n;
		end else if (mem_req) begin
			cnt_q <= cnt_q + 2'h1;
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

/* File: verification/slsu_top_sva.sv */
// Bus and trap timing checks for the load/store unit
`timescale 1ns/10ps
`default_nettype none
module slsu_top_sva
	import slsu_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Memory bus
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic        mem_byte,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        user_translate_n,
	input wire logic        mem_ack,
	input wire logic        mem_abort,
	// Traps
	input wire logic        addr_exc_trap,
	input wire logic        data_abort_trap
);
	// ------------------------------------------------
	// Checks
	// ------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Request still waiting, and request answered
	sequence s_wait; mem_req && !mem_ack && !mem_abort; endsequence
	sequence s_seen; mem_req && (mem_ack || mem_abort); endsequence
	a_req_hold: assert property (s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
		else $error("request changed before answer");
	a_req_end: assert property (s_seen |=> !mem_req)
		else $error("request kept after answer");
	a_abort_trap: assert property (mem_req && mem_abort |=> data_abort_trap ##1 !data_abort_trap)
		else $error("abort not reported as one pulse");
	a_abort_cause: assert property (data_abort_trap |-> $past(mem_abort) && $past(mem_req))
		else $error("abort trap without abort");
	a_exc_noreq: assert property (addr_exc_trap |-> !mem_req ##1 !addr_exc_trap)
		else $error("address exception with a transfer");
	a_addr_legal: assert property (mem_req |-> mem_addr[31:26] == 6'h00)
		else $error("illegal address presented");
	a_byte_lanes: assert property (mem_req && mem_we && mem_byte |-> mem_wdata == {4{mem_wdata[7:0]}})
		else $error("byte store not replicated");
	a_user_translate_n_idle: assert property (!mem_req |-> user_translate_n)
		else $error("translate line low while idle");
endmodule
bind slsu_top slsu_top_sva slsu_top_sva_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
	.mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .user_translate_n(user_translate_n),
	.mem_ack(mem_ack), .mem_abort(mem_abort), .addr_exc_trap(addr_exc_trap), .data_abort_trap(data_abort_trap));
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench: APB programmed transfers against the memory model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	import slsu_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, mem_addr, mem_wdata, mem_rdata, q;
	logic        pready, pslverr, mem_req, mem_we, mem_byte, user_translate_n, mem_ack, mem_abort;
	logic        addr_exc_trap, data_abort_trap, abort_en = 1'b0, err;
	logic [1:0]  wait_n = 2'h0;
	int          bad_count = 0, n_checks = 0, k;

	// ------------------------------------------------
	// Design, partner and clock
	// ------------------------------------------------
	slsu_top slsu_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .user_translate_n, .mem_ack, .mem_abort, .mem_rdata,
		.addr_exc_trap, .data_abort_trap);
	slsu_mem_model mdl (.pclk, .presetn, .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .user_translate_n,
		.mem_ack, .mem_abort, .mem_rdata, .abort_en, .wait_n, .user_translate_n_q());
	always #2.5 pclk = ~pclk;

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	// One APB transfer; an idle cycle follows so no signal is set twice at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(q, e)
	endtask
	function automatic logic [31:0] ins(input logic [5:0] f, input logic [3:0] rn, rd, input logic [11:0] lo);
		return {6'h00, f, rn, rd, lo};
	endfunction
	// Load base and instruction, start, poll status for done under a bound
	task automatic run(input logic [31:0] i, b, input logic [3:0] c, input logic [7:0] s);
		int n;
		apb(1'b1, OFF_BASE, b);
		apb(1'b1, OFF_INSTR, i);
		apb(1'b1, OFF_CTRL, {28'h000_0000, c | 4'h1});
		n = 0;
		q = 32'h0000_0000;
		while (q[ST_DONE] !== 1'b1 && n < 40) begin
			apb(1'b0, OFF_STATUS, 32'h0000_0000);
			n++;
		end
		`CHK(q[7:0], s)
	endtask
	task automatic summarize;
		$display("checks %0d bad %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		mdl.mem[8] = 32'h1122_3344;
		apb(1'b1, OFF_SRC, 32'h1122_3344);
		run(ins(6'h1A, 4'h1, 4'h1, 12'h010), 32'h0000_0100, 4'h0, 8'h42);
		`CHK(mdl.mem[4], 32'h1122_3344)
		rc(OFF_BASE, 32'h0000_0110);
		rc(OFF_XADDR, 32'h0000_0110);
		$display("end pre-index word store");
		wait_n <= 2'h3;
		apb(1'b1, OFF_OFFREG, 32'h0000_0001);
		apb(1'b1, OFF_SRC, 32'h0000_00A5);
		run(ins(6'h26, 4'h1, 4'h1, 12'h102), 32'h0000_0121, 4'h0, 8'h42);
		`CHK(mdl.mem[8], 32'h1122_A544)
		`CHK(mdl.user_translate_n_q, 1'b0)
		rc(OFF_BASE, 32'h0000_011D);
		wait_n <= 2'h0;
		$display("end post-index byte store");
		run(ins(6'h19, 4'h1, 4'h1, 12'h002), 32'h0000_0110, 4'h0, 8'h02);
		rc(OFF_LOADDATA, 32'h3344_1122);
		`CHK(err, 1'b0)
		`CHK(mdl.user_translate_n_q, 1'b1)
		rc(OFF_BASE, 32'h0000_0110);
		for (k = 0; k < 4; k++) begin
			run(ins(6'h1D, 4'h1, 4'h1, {10'h000, k[1:0]}), 32'h0000_0110, 4'h0, 8'h02);
			rc(OFF_LOADDATA, (32'h1122_3344 >> (8 * k)) & 32'h0000_00FF);
		end
		$display("end unaligned loads");
		run(ins(6'h19, 4'h1, 4'h1, 12'h000), 32'hFC00_0000, 4'h0, 8'h06);
		run(ins(6'h11, 4'h1, 4'h1, 12'h020), 32'h0400_0010, 4'h0, 8'h02);
		rc(OFF_XADDR, 32'h03FF_FFF0);
		abort_en <= 1'b1;
		run(ins(6'h1A, 4'h1, 4'h1, 12'h010), 32'h0000_0100, 4'h0, 8'h0A);
		rc(OFF_BASE, 32'h0000_0100);
		`CHK(mdl.mem[4], 32'h1122_3344)
		abort_en <= 1'b0;
		$display("end exceptions and abort");
		apb(1'b1, OFF_IADDR, 32'h0000_0200);
		apb(1'b1, OFF_FLAGS, 32'h0000_0003);
		run(ins(6'h19, 4'hF, 4'h1, 12'h004), 32'h0000_0000, 4'h0, 8'h02);
		rc(OFF_XADDR, 32'h0000_020C);
		run(ins(6'h39, 4'h1, 4'h1, 12'h00F), 32'h0000_0000, 4'h0, 8'h02);
		rc(OFF_XADDR, 32'h0000_020B);
		run(ins(6'h18, 4'h1, 4'hF, 12'h000), 32'h0000_0140, 4'h0, 8'h02);
		`CHK(mdl.mem[16], 32'h0000_020F)
		run(ins(6'h19, 4'h1, 4'hF, 12'h000), 32'h0000_0110, 4'h0, 8'h82);
		rc(OFF_LOADDATA, 32'h0122_3347);
		rc(OFF_FLAGS, 32'h0000_0003);
		run(ins(6'h39, 4'h1, 4'h1, 12'h012), 32'h0000_0100, 4'h0, 8'h12);
		apb(1'b1, OFF_CTRL, 32'h0000_0008);
		run(ins(6'h18, 4'h1, 4'h1, 12'h000), 32'h0000_0140, 4'h8, 8'h02);
		`CHK(mdl.user_translate_n_q, 1'b0)
		$display("end program counter operands");
		run(ins(6'h19, 4'h1, 4'h1, 12'h000), 32'h0000_0110, 4'h2, 8'h02);
		run(ins(6'h19, 4'h1, 4'h1, 12'h000), 32'h0000_0110, 4'h2, 8'h22);
		rc(OFF_LOADDATA, 32'h1122_3344);
		apb(1'b1, OFF_SRC, 32'h5566_7788);
		run(ins(6'h18, 4'h1, 4'h1, 12'h000), 32'h0000_0110, 4'h2, 8'h02);
		`CHK(mdl.mem[4], 32'h5566_7788)
		run(ins(6'h19, 4'h1, 4'h1, 12'h000), 32'h0000_0110, 4'h2, 8'h22);
		rc(OFF_LOADDATA, 32'h5566_7788);
		apb(1'b1, OFF_SRC, 32'h99AA_BBCC);
		run(ins(6'h18, 4'h1, 4'h1, 12'h000), 32'h0000_0110, 4'h4, 8'h02);
		`CHK(mdl.mem[4], 32'h99AA_BBCC)
		apb(1'b1, OFF_CTRL, 32'h0000_0002);
		run(ins(6'h19, 4'h1, 4'h1, 12'h000), 32'h0000_0110, 4'h2, 8'h22);
		rc(OFF_LOADDATA, 32'h5566_7788);
		apb(1'b1, OFF_SRC, 32'h1357_9BDF);
		run(ins(6'h18, 4'h1, 4'h1, 12'h000), 32'h0000_0110, 4'h0, 8'h02);
		apb(1'b1, OFF_CTRL, 32'h0000_0002);
		run(ins(6'h19, 4'h1, 4'h1, 12'h000), 32'h0000_0110, 4'h2, 8'h22);
		rc(OFF_LOADDATA, 32'h1357_9BDF);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		`CHK(err, 1'b1)
		`CHK(q, 32'h0000_0000)
		$display("end cache");
		summarize();
	end

	// Watchdog sized well beyond the scenario list
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire

/* File: verilog/slsu_cache.sv */
// Small direct-mapped data cache with write-through update
`timescale 1ns/10ps
`default_nettype none
module slsu_cache
	import slsu_pkg::*;
(
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Lookup side
	input  wire logic         lk_en,
	input  wire logic [31:0]  lk_addr,
	output logic              lk_hit,
	output logic [31:0]       lk_data,
	// Write side: fill allocates, update touches only a present line
	input  wire logic         wr_fill,
	input  wire logic         wr_upd,
	input  wire logic         wr_byte,
	input  wire logic [31:0]  wr_addr,
	input  wire logic [31:0]  wr_data
);
	typedef struct packed {
		logic [CACHE_LINES-1:0]                   valid;
		logic [CACHE_LINES-1:0][CACHE_TAG_W-1:0]  tag;
		logic [CACHE_LINES-1:0][31:0]             data;
	} slsu_cache_t;

	slsu_cache_t s_q;
	slsu_cache_t s_d;
	logic [1:0]  lidx;
	logic [1:0]  widx;
	logic        whit;

	// Lookup
	assign lidx    = lk_addr[3:2];
	assign widx    = wr_addr[3:2];
	assign lk_hit  = lk_en && s_q.valid[lidx] && (s_q.tag[lidx] == lk_addr[25:4]);
	assign lk_data = s_q.data[lidx];
	assign whit    = s_q.valid[widx] && (s_q.tag[widx] == wr_addr[25:4]);

	// Fill on word load miss, patch only the written lane on a byte store
	always_comb begin
		s_d = s_q;
		if (wr_fill) begin
			s_d.valid[widx] = 1'b1;
			s_d.tag[widx]   = wr_addr[25:4];
			s_d.data[widx]  = wr_data;
		end else if (wr_upd && whit) begin
			if (wr_byte)
				s_d.data[widx][{wr_addr[1:0], 3'b000} +: 8] = wr_data[7:0];
			else
				s_d.data[widx] = wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule
`default_nettype wire

/* File: verilog/slsu_pkg.sv */
// Constants, register map and types shared by the single load/store unit
package slsu_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the APB)
	// ----------------------------------------------------------------
	localparam int unsigned  AW           = 12;
	localparam logic [11:0]  OFF_CTRL     = 12'h000;
	localparam logic [11:0]  OFF_INSTR    = 12'h004;
	localparam logic [11:0]  OFF_BASE     = 12'h008;
	localparam logic [11:0]  OFF_OFFREG   = 12'h00C;
	localparam logic [11:0]  OFF_SRC      = 12'h010;
	localparam logic [11:0]  OFF_IADDR    = 12'h014;
	localparam logic [11:0]  OFF_FLAGS    = 12'h018;
	localparam logic [11:0]  OFF_STATUS   = 12'h01C;
	localparam logic [11:0]  OFF_LOADDATA = 12'h020;
	localparam logic [11:0]  OFF_WBVALUE  = 12'h024;
	localparam logic [11:0]  OFF_XADDR    = 12'h028;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned  CTRL_GO      = 0;
	localparam int unsigned  CTRL_CACHE   = 1;
	localparam int unsigned  CTRL_UPD_DIS = 2;
	localparam int unsigned  CTRL_USER    = 3;
	localparam int unsigned  ST_BUSY      = 0;
	localparam int unsigned  ST_DONE      = 1;
	localparam int unsigned  ST_ADDR_EXC  = 2;
	localparam int unsigned  ST_ABORT     = 3;
	localparam int unsigned  ST_ILLEGAL   = 4;
	localparam int unsigned  ST_HIT       = 5;
	localparam int unsigned  ST_WB        = 6;
	localparam int unsigned  ST_PC_ONLY   = 7;
	localparam int unsigned  IN_REG_OFF   = 25;
	localparam int unsigned  IN_PRE       = 24;
	localparam int unsigned  IN_UP        = 23;
	localparam int unsigned  IN_BYTE      = 22;
	localparam int unsigned  IN_WB        = 21;
	localparam int unsigned  IN_LOAD      = 20;
	localparam int unsigned  IN_RN_LSB    = 16;
	localparam int unsigned  IN_RD_LSB    = 12;
	localparam int unsigned  IN_SH_AMT    = 7;
	localparam int unsigned  IN_SH_TYPE   = 5;
	localparam int unsigned  IN_SH_REG    = 4;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [31:0]  RST_WORD     = 32'h0000_0000;
	localparam logic [3:0]   PC_REG_NUM   = 4'hF;
	localparam logic [31:0]  PC_AHEAD_OP  = 32'h0000_0008;
	localparam logic [31:0]  PC_AHEAD_ST  = 32'h0000_000C;
	localparam logic [31:0]  PC_MASK      = 32'h03FF_FFFC;
	localparam logic [31:0]  PSR_MASK     = 32'hFC00_0003;
	localparam logic [31:0]  ADDR_BAD     = 32'hFC00_0000;
	localparam int unsigned  CACHE_LINES  = 4;
	localparam int unsigned  CACHE_TAG_W  = 22;

	typedef enum logic [1:0] {
		SH_LSL = 2'b00,
		SH_LSR = 2'b01,
		SH_ASR = 2'b10,
		SH_ROR = 2'b11
	} slsu_shift_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_BUS  = 2'b01
	} slsu_state_t;

endpackage

/* File: verilog/slsu_shifter.sv */
// Immediate-count barrel shifter for register offsets
`timescale 1ns/10ps
`default_nettype none
module slsu_shifter
	import slsu_pkg::*;
(
	// Operand
	input  wire logic [31:0]  value,
	input  wire logic         carry_in,
	// Shift control, count always from the instruction
	input  wire slsu_shift_t  sh_type,
	input  wire logic [4:0]   amount,
	// Result
	output logic [31:0]       result
);
	logic [63:0] dbl;

	// Count zero encodes LSR/ASR by 32 and RRX
	always_comb begin
		dbl    = {value, value} >> amount;
		result = value;
		unique case (sh_type)
			SH_LSL: result = value << amount;
			SH_LSR: result = (amount == 5'd0) ? RST_WORD : (value >> amount);
			SH_ASR: result = (amount == 5'd0) ? {32{value[31]}} : 32'($signed(value) >>> amount);
			SH_ROR: result = (amount == 5'd0) ? {carry_in, value[31:1]} : dbl[31:0];
		endcase
	end

endmodule
`default_nettype wire

/* File: verilog/slsu_top.sv */
// Single-register load/store unit with APB control and memory bus master
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module slsu_top
	import slsu_pkg::*;
(
	// Clock and reset
	input  wire logic           pclk,
	input  wire logic           presetn,
	// APB slave
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [AW-1:0]  paddr,
	input  wire logic [31:0]    pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	// Memory bus master
	output logic                mem_req,
	output logic                mem_we,
	output logic                mem_byte,
	output logic [31:0]         mem_addr,
	output logic [31:0]         mem_wdata,
	output logic                user_translate_n,
	input  wire logic           mem_ack,
	input  wire logic           mem_abort,
	input  wire logic [31:0]    mem_rdata,
	// Trap indications, one cycle each
	output logic                addr_exc_trap,
	output logic                data_abort_trap
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		slsu_state_t  state;
		logic [31:0]  instr;
		logic [31:0]  base;
		logic [31:0]  offreg;
		logic [31:0]  src;
		logic [31:0]  iaddr;
		logic [31:0]  flags;
		logic         cache_en;
		logic         upd_dis;
		logic         user_mode;
		logic         op_load;
		logic         op_byte;
		logic         op_wb;
		logic         op_rd_pc;
		logic         op_rn_pc;
		logic [31:0]  wb_pend;
		logic         mem_req;
		logic         mem_we;
		logic         mem_byte;
		logic [31:0]  mem_addr;
		logic [31:0]  mem_wdata;
		logic         user_translate_n_n;
		logic [7:0]   status;
		logic [31:0]  load_data;
		logic [31:0]  wb_value;
		logic [31:0]  xaddr;
		logic [31:0]  prdata;
		logic         exc_trap;
		logic         abt_trap;
	} slsu_top_t;

	slsu_top_t    s_q;
	slsu_top_t    s_d;

	// Decode and datapath nets
	logic         wr_acc;
	logic         rd_setup;
	logic         mapped;
	logic         go;
	logic         rn_pc;
	logic         rm_pc;
	logic         rd_pc;
	logic [31:0]  pc_op;
	logic [31:0]  pc_st;
	logic [31:0]  base_v;
	logic [31:0]  offreg_v;
	logic [31:0]  src_v;
	logic [31:0]  sh_out;
	logic [31:0]  offset;
	logic [31:0]  modified;
	logic [31:0]  xaddr;
	logic         addr_bad;
	logic         illegal;
	logic         pre;
	logic         do_wb;
	logic         c_hit;
	logic [31:0]  c_data;
	logic [31:0]  raw_word;
	logic [1:0]   lane_addr;
	logic [63:0]  dbl;
	logic [31:0]  rot;
	logic [31:0]  ld_val;
	logic         bus_end;
	logic         fill_en;
	logic         upd_en;
	logic [31:0]  c_wdata;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero wait states; read data is captured in the setup cycle
	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !mapped;
	assign go       = wr_acc && (paddr == OFF_CTRL) && pwdata[CTRL_GO] && (s_q.state == S_IDLE);

	always_comb begin
		unique case (paddr)
			OFF_CTRL, OFF_INSTR, OFF_BASE, OFF_OFFREG,
			OFF_SRC, OFF_IADDR, OFF_FLAGS, OFF_STATUS,
			OFF_LOADDATA, OFF_WBVALUE, OFF_XADDR: mapped = 1'b1;
			default:                              mapped = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Operand selection
	// ----------------------------------------------------------------
	// The program counter reads differently by operand position
	assign rn_pc    = (s_q.instr[IN_RN_LSB +: 4] == PC_REG_NUM);
	assign rm_pc    = (s_q.instr[3:0] == PC_REG_NUM);
	assign rd_pc    = (s_q.instr[IN_RD_LSB +: 4] == PC_REG_NUM);
	assign pc_op    = (s_q.iaddr + PC_AHEAD_OP) & PC_MASK;
	assign pc_st    = (s_q.iaddr + PC_AHEAD_ST) & PC_MASK;
	assign base_v   = rn_pc ? pc_op : s_q.base;
	assign offreg_v = rm_pc ? (pc_op | (s_q.flags & PSR_MASK)) : s_q.offreg;
	assign src_v    = rd_pc ? (pc_st | (s_q.flags & PSR_MASK)) : s_q.src;

	// Shift count from bits 11:7 only; a register count is flagged
	slsu_shifter u_shift (
		.value    (offreg_v),
		.carry_in (s_q.flags[29]),
		.sh_type  (slsu_shift_t'(s_q.instr[IN_SH_TYPE +: 2])),
		.amount   (s_q.instr[IN_SH_AMT +: 5]),
		.result   (sh_out)
	);

	// ----------------------------------------------------------------
	// Address generation and checks
	// ----------------------------------------------------------------
	assign illegal  = s_q.instr[IN_REG_OFF] && s_q.instr[IN_SH_REG];
	assign offset   = s_q.instr[IN_REG_OFF] ? sh_out : {20'h0_0000, s_q.instr[11:0]};
	assign modified = s_q.instr[IN_UP] ? (base_v + offset) : (base_v - offset);
	assign pre      = s_q.instr[IN_PRE];
	assign xaddr    = pre ? modified : base_v;
	assign do_wb    = !pre || s_q.instr[IN_WB];
	// Only the presented address is tested, never the written-back one
	assign addr_bad = |(xaddr & ADDR_BAD);

	// ----------------------------------------------------------------
	// Cache
	// ----------------------------------------------------------------
	assign bus_end = (s_q.state == S_BUS) && (mem_ack || mem_abort);
	assign fill_en = bus_end && !mem_abort && s_q.op_load && !s_q.op_byte && s_q.cache_en;
	// Store updates happen even with the cache off, to keep it coherent
	assign upd_en  = bus_end && !mem_abort && !s_q.op_load && !s_q.upd_dis;
	// A fill must take the raw bus word; the store data register holds the source
	assign c_wdata = fill_en ? mem_rdata : s_q.mem_wdata;

	slsu_cache u_cache (
		.pclk    (pclk),
		.presetn (presetn),
		.lk_en   (s_q.cache_en),
		.lk_addr (xaddr),
		.lk_hit  (c_hit),
		.lk_data (c_data),
		.wr_fill (fill_en),
		.wr_upd  (upd_en),
		.wr_byte (s_q.op_byte),
		.wr_addr (s_q.mem_addr),
		.wr_data (c_wdata)
	);

	// ----------------------------------------------------------------
	// Load data formatting
	// ----------------------------------------------------------------
	// Little-endian lanes: rotate right by eight times the byte offset
	always_comb begin
		if (s_q.state == S_BUS) begin
			raw_word  = mem_rdata;
			lane_addr = s_q.mem_addr[1:0];
		end else begin
			raw_word  = c_data;
			lane_addr = xaddr[1:0];
		end
		dbl = {raw_word, raw_word} >> {lane_addr, 3'b000};
		rot = dbl[31:0];
		if (s_q.state == S_BUS ? s_q.op_byte : s_q.instr[IN_BYTE])
			ld_val = {24'h00_0000, rot[7:0]};
		else
			ld_val = rot;
		// A load into the program counter keeps the current flags
		if (s_q.state == S_BUS ? s_q.op_rd_pc : rd_pc)
			ld_val = (ld_val & PC_MASK) | (s_q.flags & PSR_MASK);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d          = s_q;
		s_d.exc_trap = 1'b0;
		s_d.abt_trap = 1'b0;

		// Register writes; flags only ever change from software
		if (wr_acc) begin
			unique case (paddr)
				OFF_CTRL: begin
					s_d.cache_en  = pwdata[CTRL_CACHE];
					s_d.upd_dis   = pwdata[CTRL_UPD_DIS];
					s_d.user_mode = pwdata[CTRL_USER];
				end
				OFF_INSTR:  s_d.instr  = pwdata;
				OFF_BASE:   s_d.base   = pwdata;
				OFF_OFFREG: s_d.offreg = pwdata;
				OFF_SRC:    s_d.src    = pwdata;
				OFF_IADDR:  s_d.iaddr  = pwdata;
				OFF_FLAGS:  s_d.flags  = pwdata & PSR_MASK;
				default: ;
			endcase
		end

		unique case (s_q.state)
			S_IDLE: begin
				if (go) begin
					s_d.status   = '0;
					s_d.xaddr    = xaddr;
					s_d.op_load  = s_q.instr[IN_LOAD];
					s_d.op_byte  = s_q.instr[IN_BYTE];
					s_d.op_wb    = do_wb;
					s_d.op_rd_pc = rd_pc;
					s_d.op_rn_pc = rn_pc;
					s_d.wb_pend  = modified;
					if (illegal) begin
						s_d.status[ST_ILLEGAL] = 1'b1;
						s_d.status[ST_DONE]    = 1'b1;
					end else if (addr_bad) begin
						// Suppressed: no bus cycle and no write-back
						s_d.status[ST_ADDR_EXC] = 1'b1;
						s_d.status[ST_DONE]     = 1'b1;
						s_d.exc_trap            = 1'b1;
					end else if (s_q.instr[IN_LOAD] && c_hit) begin
						s_d.load_data       = ld_val;
						s_d.status[ST_HIT]  = 1'b1;
						s_d.status[ST_DONE] = 1'b1;
						s_d.status[ST_PC_ONLY] = rd_pc;
						if (do_wb) begin
							s_d.wb_value      = modified;
							s_d.status[ST_WB] = 1'b1;
							if (!rn_pc)
								s_d.base = modified;
						end
					end else begin
						s_d.state     = S_BUS;
						s_d.status[ST_BUSY] = 1'b1;
						s_d.mem_req   = 1'b1;
						s_d.mem_we    = !s_q.instr[IN_LOAD];
						s_d.mem_byte  = s_q.instr[IN_BYTE];
						s_d.mem_addr  = xaddr;
						s_d.mem_wdata = s_q.instr[IN_BYTE] ? {4{src_v[7:0]}} : src_v;
						// User translation forced for post-index with write-back
						s_d.user_translate_n_n   = !(!pre && s_q.instr[IN_WB] && !s_q.user_mode)
						                && !s_q.user_mode;
					end
				end
			end
			S_BUS: begin
				if (bus_end) begin
					s_d.state           = S_IDLE;
					s_d.mem_req         = 1'b0;
					s_d.mem_we          = 1'b0;
					s_d.user_translate_n_n         = 1'b1;
					s_d.status[ST_BUSY] = 1'b0;
					s_d.status[ST_DONE] = 1'b1;
					if (mem_abort) begin
						// Nothing is committed, so the transfer can be retried
						s_d.status[ST_ABORT] = 1'b1;
						s_d.abt_trap         = 1'b1;
					end else begin
						if (s_q.op_load) begin
							s_d.load_data          = ld_val;
							s_d.status[ST_PC_ONLY] = s_q.op_rd_pc;
						end
						if (s_q.op_wb) begin
							s_d.wb_value      = s_q.wb_pend;
							s_d.status[ST_WB] = 1'b1;
							if (!s_q.op_rn_pc)
								s_d.base = s_q.wb_pend;
						end
					end
				end
			end
			default: s_d.state = S_IDLE;
		endcase

		// Read data captured at setup so it is steady for the access phase
		if (rd_setup) begin
			unique case (paddr)
				OFF_CTRL:     s_d.prdata = {28'h000_0000, s_q.user_mode, s_q.upd_dis, s_q.cache_en, 1'b0};
				OFF_INSTR:    s_d.prdata = s_q.instr;
				OFF_BASE:     s_d.prdata = s_q.base;
				OFF_OFFREG:   s_d.prdata = s_q.offreg;
				OFF_SRC:      s_d.prdata = s_q.src;
				OFF_IADDR:    s_d.prdata = s_q.iaddr;
				OFF_FLAGS:    s_d.prdata = s_q.flags;
				OFF_STATUS:   s_d.prdata = {24'h00_0000, s_q.status};
				OFF_LOADDATA: s_d.prdata = s_q.load_data;
				OFF_WBVALUE:  s_d.prdata = s_q.wb_value;
				OFF_XADDR:    s_d.prdata = s_q.xaddr;
				default:      s_d.prdata = RST_WORD;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q         <= '0;
			s_q.state   <= S_IDLE;
			s_q.user_translate_n_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign prdata           = s_q.prdata;
	assign mem_req          = s_q.mem_req;
	assign mem_we           = s_q.mem_we;
	assign mem_byte         = s_q.mem_byte;
	assign mem_addr         = s_q.mem_addr;
	assign mem_wdata        = s_q.mem_wdata;
	assign user_translate_n = s_q.user_translate_n_n;
	assign addr_exc_trap    = s_q.exc_trap;
	assign data_abort_trap  = s_q.abt_trap;

endmodule
`default_nettype wire
